// file: rtl/abs_pos_pkg.sv
// constants and types for the absolute position status block
package abs_pos_pkg;
	// register addresses, one per 16-bit word
	localparam logic [15:0] ADDR_MSG_SEL   = 16'h0372;
	localparam logic [15:0] ADDR_POS_RST   = 16'h0374;
	localparam logic [15:0] ADDR_POS_RST_H = 16'h0375;
	localparam logic [15:0] ADDR_STATUS    = 16'h0376;
	localparam logic [15:0] ADDR_STATUS_H  = 16'h0377;
	localparam logic [15:0] ADDR_TURN_LO   = 16'h0378;
	localparam logic [15:0] ADDR_TURN_HI   = 16'h0379;
	localparam logic [15:0] ADDR_SINGLE_LO = 16'h037a;
	localparam logic [15:0] ADDR_SINGLE_HI = 16'h037b;
	localparam logic [15:0] ADDR_ZWID      = 16'h037c;
	localparam logic [15:0] ADDR_ZWID_H    = 16'h037d;
	localparam logic [15:0] ADDR_IRQ_STAT  = 16'h0380;
	localparam logic [15:0] ADDR_IRQ_MASK  = 16'h0382;

	// field positions of the selection word
	localparam int SEL_IO_UNIT  = 0;
	localparam int SEL_COM_UNIT = 1;
	localparam int SEL_NO_OVF   = 2;
	localparam logic [2:0] SEL_MASK = 3'h7;

	// reset values
	localparam logic [15:0] MSG_SEL_RST = 16'h0000;
	localparam logic [15:0] POS_RST_RST = 16'h0000;
	localparam logic [15:0] ZWID_RST    = 16'h0001;

	// zeroing command value
	localparam logic [15:0] POS_RST_CMD = 16'h0111;

	// index width setting range
	localparam logic [15:0] ZWID_MIN = 16'h0001;
	localparam logic [15:0] ZWID_MAX = 16'h0032;

	// index width timing per setting step
	localparam int CLK_PERIOD_NS = 20;
	localparam int ZSTEP_NS      = 125000;
	localparam int ZSTEP_CYC     = ZSTEP_NS / CLK_PERIOD_NS;

	// single-turn range is 1048576 pulses
	localparam int SINGLE_BITS = 20;

	// interrupt event bit positions
	localparam int EV_ZEROED   = 0;
	localparam int EV_ALARM_A  = 1;
	localparam int EV_ALARM_B  = 2;
	localparam int EV_POS_LOST = 3;
	localparam int EV_BITS     = 4;

	// encoder position data
	typedef struct packed {
		logic [31:0]            turns;
		logic [SINGLE_BITS-1:0] single;
		logic [31:0]            userPos;
	} enc_pos_s;

	// encoder condition flags, low bits of the status word
	typedef struct packed {
		logic coordUnset;
		logic userOvf;
		logic turnOvf;
		logic batLow;
		logic posLost;
	} enc_flags_s;
endpackage

// file: rtl/absolute_position_status.sv
// absolute encoder position status and parameter registers
//
// Overview of operation
// - selection bit 2 high suppresses both overflow alarms; low enables them
// - selection word bits 3 to 15 read back as zero
// - writing 0x111 to the reset parameter zeroes encoder absolute position
// - coordinate clear input rising edge zeroes position as the reset write does, two cycles later through its synchroniser
// - status bit 0 shows absolute position lost
// - status bit 1 shows backup battery voltage low
// - status bit 2 shows absolute turn count overflow
// - status bit 3 shows user unit position overflow
// - status bit 4 shows coordinate system not yet established
// - status bits 5 to 15 read back as zero
// - pulse mode: turn count readback gives encoder absolute turns
// - user unit mode: turn count readback gives zero
// - pulse mode: single-turn readback gives pulses within one revolution
// - user unit mode: single-turn readback gives signed 32-bit position
// - index output pulse width follows width setting, 1 to 50
// - each width step lasts 125 us, 6250 us at setting 50
// - selection bit 1 picks readback unit: 1 pulses, 0 user units
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module absolute_position_status
	import abs_pos_pkg::*;
#(
	parameter int STEP_CYC = ZSTEP_CYC    // cycles per width step
) (
	input  wire logic        ref_clk,     // 50 MHz clock
	input  wire logic        nrst,        // async reset, active low
	input  wire logic [15:0] regAddr,     // register address
	input  wire logic [15:0] regWdata,    // write data
	input  wire logic        regWr,       // write strobe
	input  wire logic        regRd,       // read strobe
	output logic      [15:0] regRdata,    // read data, cycle after strobe
	input  wire enc_pos_s    encPos,      // encoder position, same clock
	input  wire enc_flags_s  encFlags,    // encoder flags, same clock
	input  wire logic        encIndex,    // encoder index event pulse
	input  wire logic        clearPin,    // coordinate clear input pin
	output logic             posZero,     // zero position pulse to encoder
	output logic             indexOut,    // index output pulse
	output logic             alarmA,      // turn overflow alarm
	output logic             alarmB,      // user unit overflow alarm
	output logic             irq          // interrupt, level
);

	// register state
	logic [2:0]         msgSel_q;
	logic [15:0]        posRst_q;
	logic [15:0]        zWidth_q;
	logic [EV_BITS-1:0] irqStat_q;
	logic [EV_BITS-1:0] irqMask_q;
	logic [15:0]        regRdata_q;

	// clear pin synchroniser and edge
	logic clrMeta_q;
	logic clrSync_q;
	logic clrPrev_q;
	logic clrRise;

	// command and alarm state
	logic posZero_q;
	logic alarmA_q;
	logic alarmB_q;
	logic lostPrev_q;
	logic zeroCmd;
	logic [EV_BITS-1:0] events;

	// index pulse stretcher
	logic        index_q;
	logic [15:0] stepLeft_q;
	logic [31:0] cycLeft_q;
	logic        cycDone;
	logic        stepDone;

	// decoded strobes
	logic wrSel;
	logic wrRst;
	logic wrZw;
	logic wrIrqStat;
	logic wrIrqMask;

	// readback words
	logic        pulseMode;
	logic [15:0] statusWord;
	logic [31:0] turnWord;
	logic [31:0] singleWord;

	// write decode; read-only words have no write strobe
	// status, turn and single words decode nothing, so a host write
	// there simply vanishes instead of disturbing live encoder data
	// read-only ignored
	always_comb begin
		wrSel     = regWr && (regAddr == ADDR_MSG_SEL);
		wrRst     = regWr && (regAddr == ADDR_POS_RST);
		wrZw      = regWr && (regAddr == ADDR_ZWID);
		wrIrqStat = regWr && (regAddr == ADDR_IRQ_STAT);
		wrIrqMask = regWr && (regAddr == ADDR_IRQ_MASK);
	end

	// selection word, three live bits
	// reserved bits dropped
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			msgSel_q <= MSG_SEL_RST[2:0];
		end else if (wrSel) begin
			msgSel_q <= regWdata[2:0] & SEL_MASK;
		end
	end

	// reset parameter holds last value written
	// only the command value acts; any other value is just kept
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			posRst_q <= POS_RST_RST;
		end else if (wrRst) begin
			posRst_q <= regWdata;
		end
	end

	// index width, out-of-range writes keep old value
	// keeping the old width avoids a pulse longer than 50 steps from a bad write
	// width range
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			zWidth_q <= ZWID_RST;
		end else if (wrZw && regWdata >= ZWID_MIN
				&& regWdata <= ZWID_MAX) begin
			zWidth_q <= regWdata;
		end
	end

	// clear pin: two flops before any logic looks at it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clrMeta_q <= 1'b0;
			clrSync_q <= 1'b0;
		end else begin
			clrMeta_q <= clearPin;
			clrSync_q <= clrMeta_q;
		end
	end

	// previous synchronised level; resets to the idle low of the pin
	// so that release of reset with the pin low never looks like a rising edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clrPrev_q <= 1'b0;
		end else begin
			clrPrev_q <= clrSync_q;
		end
	end

	assign clrRise = clrSync_q && !clrPrev_q;

	// zeroing request from either source
	// a held pin gives one request only, since just its edge counts
	// 0x111 command
	assign zeroCmd = (wrRst && regWdata == POS_RST_CMD) || clrRise;

	// one-cycle zeroing pulse to the encoder
	// registered so the encoder sees a clean pulse, one cycle late
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			posZero_q <= 1'b0;
		end else begin
			posZero_q <= zeroCmd;
		end
	end

	assign posZero = posZero_q;

	// overflow alarms follow the encoder flags one cycle late; the
	// suppress bit gates the alarms, not the flags, so the status word
	// still shows an overflow while the alarm stays quiet
	// turn overflow alarm
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			alarmA_q <= 1'b0;
		end else begin
			alarmA_q <= encFlags.turnOvf && !msgSel_q[SEL_NO_OVF];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			alarmB_q <= 1'b0;
		end else begin
			alarmB_q <= encFlags.userOvf && !msgSel_q[SEL_NO_OVF];
		end
	end

	assign alarmA = alarmA_q;
	assign alarmB = alarmB_q;

	// previous lost flag for event edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lostPrev_q <= 1'b0;
		end else begin
			lostPrev_q <= encFlags.posLost;
		end
	end

	// interrupt events, single-cycle each
	// alarm events fire on the rise only, so a standing overflow
	// does not refill the status bit after software clears it
	always_comb begin
		events = '0;
		events[EV_ZEROED]   = zeroCmd;
		events[EV_ALARM_A]  = encFlags.turnOvf && !msgSel_q[SEL_NO_OVF]
			&& !alarmA_q;
		events[EV_ALARM_B]  = encFlags.userOvf && !msgSel_q[SEL_NO_OVF]
			&& !alarmB_q;
		events[EV_POS_LOST] = encFlags.posLost && !lostPrev_q;
	end

	// sticky status, write one clears, a new event wins
	// letting the event win means no event is lost to a racing clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqStat_q <= '0;
		end else begin
			irqStat_q <= (irqStat_q
				& ~(wrIrqStat ? regWdata[EV_BITS-1:0] : '0)) | events;
		end
	end

	// interrupt mask, all events masked after reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqMask_q <= '0;
		end else if (wrIrqMask) begin
			irqMask_q <= regWdata[EV_BITS-1:0];
		end
	end

	assign irq = |(irqStat_q & irqMask_q);

	// index pulse: setting times step length, restarted by each index
	// a fresh index restarts the whole pulse, so a fast encoder keeps
	// the output high rather than cutting a pulse short
	// 125 us step
	assign cycDone  = (cycLeft_q == '0);
	assign stepDone = (stepLeft_q == '0);

	// output level
	// width from setting
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			index_q <= 1'b0;
		end else if (encIndex) begin
			index_q <= 1'b1;
		end else if (index_q && cycDone && stepDone) begin
			index_q <= 1'b0;
		end
	end

	// steps still to run after the current one
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stepLeft_q <= '0;
		end else if (encIndex) begin
			stepLeft_q <= zWidth_q - 16'h0001;
		end else if (index_q && cycDone && !stepDone) begin
			stepLeft_q <= stepLeft_q - 16'h0001;
		end
	end

	// cycles left in the current step
	// step length
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cycLeft_q <= '0;
		end else if (encIndex) begin
			cycLeft_q <= 32'(STEP_CYC - 1);
		end else if (index_q && !cycDone) begin
			cycLeft_q <= cycLeft_q - 32'h1;
		end else if (index_q && !stepDone) begin
			cycLeft_q <= 32'(STEP_CYC - 1);
		end
	end

	assign indexOut = index_q;

	// readback unit select
	// the unit is chosen per read, so a mode change shows at once
	// unit select
	assign pulseMode = msgSel_q[SEL_COM_UNIT];

	// status word from encoder flags
	// position lost
	assign statusWord = {11'h000, encFlags};

	// turn count readback
	// turns in pulse mode
	assign turnWord = pulseMode ? encPos.turns : 32'h0000_0000;

	// single-turn readback
	// pulse count
	assign singleWord = pulseMode
		? {12'h000, encPos.single} : encPos.userPos;

	// read mux, registered; unmapped addresses read zero
	// halves of 32-bit words are not latched together, so a moving
	// position can give halves from different cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			regRdata_q <= '0;
		end else if (regRd) begin
			case (regAddr)
				ADDR_MSG_SEL: begin
					regRdata_q <= {13'h0000, msgSel_q};
				end
				ADDR_POS_RST: begin
					regRdata_q <= posRst_q;
				end
				ADDR_STATUS: begin
					regRdata_q <= statusWord;
				end
				ADDR_TURN_LO: begin
					regRdata_q <= turnWord[15:0];
				end
				ADDR_TURN_HI: begin
					regRdata_q <= turnWord[31:16];
				end
				ADDR_SINGLE_LO: begin
					regRdata_q <= singleWord[15:0];
				end
				ADDR_SINGLE_HI: begin
					regRdata_q <= singleWord[31:16];
				end
				ADDR_ZWID: begin
					regRdata_q <= zWidth_q;
				end
				ADDR_IRQ_STAT: begin
					regRdata_q <= {12'h000, irqStat_q};
				end
				ADDR_IRQ_MASK: begin
					regRdata_q <= {12'h000, irqMask_q};
				end
				default: begin
					regRdata_q <= '0;
				end
			endcase
		end else begin
			regRdata_q <= '0;
		end
	end

	assign regRdata = regRdata_q;

endmodule

`default_nettype wire

// file: tb/abs_pos_chk.sv
// assertion checker for the absolute position status block
`timescale 1ns/10ps
`default_nettype none
module abs_pos_chk
	import abs_pos_pkg::*;
#(parameter int STEP_CYC = 4) (
	input wire logic        ref_clk,  // clock
	input wire logic        nrst,     // reset
	input wire logic [15:0] regAddr,  // address
	input wire logic [15:0] regWdata, // data in
	input wire logic        regWr,    // write
	input wire logic        regRd,    // read
	input wire logic [15:0] regRdata, // data out
	input wire enc_pos_s    encPos,   // position
	input wire enc_flags_s  encFlags, // flags
	input wire logic        encIndex, // index in
	input wire logic        clearPin, // clear pin
	input wire logic        posZero,  // zero pulse
	input wire logic        indexOut, // index out
	input wire logic        alarmA    // alarm
);
	logic [2:0]  selQ;
	logic [15:0] widQ;
	logic [31:0] runQ;
	// shadow settings and index run length
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			selQ <= 3'h0;
			widQ <= ZWID_RST;
			runQ <= 32'h0;
		end else begin
			if (regWr && regAddr == ADDR_MSG_SEL)
				selQ <= regWdata[2:0];
			if (regWr && regAddr == ADDR_ZWID && regWdata >= ZWID_MIN
				&& regWdata <= ZWID_MAX)
				widQ <= regWdata;
			runQ <= encIndex ? 32'h0 : runQ + {31'h0, indexOut};
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence zeroCmd;
		regWr && regAddr == ADDR_POS_RST && regWdata == POS_RST_CMD;
	endsequence
	sequence rdOf(a);
		regRd && regAddr == a;
	endsequence
	zero_cmd_a:
		assert property (zeroCmd |=> posZero) else $error("no zero");
	zero_once_a:
		assert property (posZero |=> !posZero) else $error("long zero");
	clear_zero_a:
		assert property ($rose(clearPin) |-> ##[2:4] posZero)
			else $error("clear lost");
	status_rd_a:
		assert property (rdOf(ADDR_STATUS) |=>
			regRdata == {11'h0, $past(encFlags)}) else $error("bad status");
	turn_rd_a:
		assert property (rdOf(ADDR_TURN_HI) |=> regRdata == ($past(selQ[1])
			? $past(encPos.turns[31:16]) : 16'h0)) else $error("bad turns");
	single_rd_a:
		assert property (rdOf(ADDR_SINGLE_LO) |=>
			regRdata == ($past(selQ[1]) ? $past(encPos.single[15:0])
			: $past(encPos.userPos[15:0]))) else $error("bad single");
	ovf_alarm_a:
		assert property (1 |=> alarmA == $past(encFlags.turnOvf && !selQ[2]))
			else $error("bad alarm");
	index_width_a:
		assert property ($fell(indexOut) |-> runQ == 32'(widQ) * STEP_CYC)
			else $error("bad index width");
endmodule
bind absolute_position_status abs_pos_chk #(.STEP_CYC(STEP_CYC)) chk (.*);
`default_nettype wire

// file: tb/enc_model.sv
// behavioural absolute encoder for the bench
`timescale 1ns/10ps
`default_nettype none
module enc_model
	import abs_pos_pkg::*;
(
	input  wire logic    ref_clk,  // clock
	input  wire logic    nrst,     // reset
	input  wire logic    spin,     // turn once
	input  wire logic    posZero,  // zero request
	output var enc_pos_s encPos,   // position
	output var logic     encIndex  // index event
);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			encPos <= '0;
			encIndex <= 1'b0;
		end else if (posZero) begin
			encPos <= '0;
			encIndex <= 1'b0;
		end else begin
			encIndex <= spin;
			if (spin) begin
				encPos.turns <= encPos.turns + 32'h1;
				encPos.single <= encPos.single + 20'h12345;
				encPos.userPos <= encPos.userPos - 32'h10;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/absolute_position_status_test.sv
// self-checking bench for the absolute position status block
`timescale 1ns/10ps
`default_nettype none
module absolute_position_status_test
	import abs_pos_pkg::*;
;
	localparam int SC = 4;  // shortened width step
	logic        ref_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic        clearPin = 1'b0, spin = 1'b0;
	logic [15:0] regAddr = 16'h0, regWdata = 16'h0, regRdata;
	logic        encIndex, posZero, indexOut, alarmA, alarmB, irq;
	enc_flags_s  encFlags = '0;
	enc_pos_s    encPos;
	int          num_errors = 0, n_compared = 0, cyc = 0;
	absolute_position_status #(.STEP_CYC(SC)) dut (.ref_clk, .nrst,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata, .encPos, .encFlags,
		.encIndex, .clearPin, .posZero, .indexOut, .alarmA, .alarmB, .irq);
	enc_model model (.ref_clk, .nrst, .spin, .posZero, .encPos, .encIndex);
	// clock and hang guard
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rc(input logic [15:0] a, exp);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
		@(posedge ref_clk);
	endtask
	// one encoder turn, counting index output cycles
	task automatic turn(input int n, output logic [15:0] hi);
		spin <= 1'b1;
		hi = 16'h0;
		@(posedge ref_clk);
		spin <= 1'b0;
		repeat (n) begin
			@(posedge ref_clk);
			hi += {15'h0, indexOut};
		end
	endtask
	task automatic t_regs;
		rc(ADDR_POS_RST, POS_RST_RST);
		rc(ADDR_ZWID, ZWID_RST);
		wr(ADDR_MSG_SEL, 16'hffff);
		rc(ADDR_MSG_SEL, 16'h0007);
		wr(ADDR_STATUS, 16'hffff);
		rc(ADDR_STATUS, 16'h0000);
		rc(16'h0390, 16'h0000);
		$display("regs ok");
	endtask
	task automatic t_status;
		for (int i = 0; i < 5; i++) begin
			encFlags <= enc_flags_s'(5'h1 << i);
			rc(ADDR_STATUS, 16'h1 << i);
		end
		encFlags <= '1;
		rc(ADDR_STATUS, 16'h001f);
		rc(ADDR_IRQ_STAT, 16'h0008);
		$display("status ok");
	endtask
	task automatic t_alarm;
		for (int s = 0; s < 2; s++) begin
			encFlags <= '0;
			wr(ADDR_MSG_SEL, s ? 16'h0004 : 16'h0000);
			encFlags <= enc_flags_s'(5'h0c);
			repeat (3) @(posedge ref_clk);
			chk({14'h0, alarmA, alarmB}, s ? 16'h0 : 16'h3);
		end
		encFlags <= '0;
		rc(ADDR_IRQ_STAT, 16'h000e);
		$display("alarm ok");
	endtask
	task automatic t_read;
		logic [15:0] h;
		turn(8, h);
		turn(8, h);
		wr(ADDR_MSG_SEL, 16'h0002);
		rc(ADDR_TURN_LO, 16'h0002);
		rc(ADDR_SINGLE_LO, 16'h468a);
		rc(ADDR_SINGLE_HI, 16'h0002);
		wr(ADDR_MSG_SEL, 16'h0000);
		rc(ADDR_TURN_LO, 16'h0000);
		rc(ADDR_SINGLE_LO, 16'hffe0);
		rc(ADDR_SINGLE_HI, 16'hffff);
		$display("readback ok");
	endtask
	task automatic t_zero;
		logic [15:0] h;
		wr(ADDR_MSG_SEL, 16'h0002);
		wr(ADDR_IRQ_STAT, 16'h000f);
		wr(ADDR_IRQ_MASK, 16'h0001);
		wr(ADDR_POS_RST, 16'h0110);
		rc(ADDR_TURN_LO, 16'h0002);
		wr(ADDR_POS_RST, POS_RST_CMD);
		rc(ADDR_TURN_LO, 16'h0000);
		chk({15'h0, irq}, 16'h0001);
		wr(ADDR_IRQ_STAT, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		turn(8, h);
		clearPin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		clearPin <= 1'b0;
		rc(ADDR_TURN_LO, 16'h0000);
		chk({15'h0, irq}, 16'h0001);
		wr(ADDR_IRQ_MASK, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		$display("zero ok");
	endtask
	task automatic t_index;
		logic [15:0] h;
		wr(ADDR_ZWID, 16'h0033);
		rc(ADDR_ZWID, ZWID_MIN);
		turn(12, h);
		chk(h, 16'(SC));
		wr(ADDR_ZWID, ZWID_MAX);
		turn(60 * SC, h);
		chk(h, 16'(50 * SC));
		$display("index ok");
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_status();
		t_alarm();
		t_read();
		t_zero();
		t_index();
		wrap_up();
	end
endmodule
`default_nettype wire
